// *** rtl/ffam_fault_alert.sv ***
// Purpose: Output fault filter, crowbar, external temperature scaling and alert masking.
// Assumes: Bus physical layer decodes transactions into command, byte and stop strobes.
// Notes: Local fault flags are sticky until i_clear_faults; a set in that cycle wins.
`timescale 1ns/1ns
`default_nettype none
// Contract
// [R1] Fault starts after field plus one violations.
// [R2] Crowbar bit turns low-side device on.
// [R3] Temperature equals raw over gain plus bias.
// [R4] Mask is seven bytes, one per status.
// [R5] Mask one blocks alert, zero allows.
// [R6] Bit 55 gates phase init error.
// [R7] Bit 54 gates group bus error.
// [R8] Aux undervoltage warning at 110 percent.
// [R9] Aux overvoltage warning at 95 percent.
// [R10] Sync clock loss flags switching period fault.
// [R11] Bit 50 gates group rail fault.
// [R12] Bits 49, 48 gate aux faults.
// [R13] Bit 39 gates invalid command.
// [R14] Bit 38 gates invalid data.
// [R15] Bit 37 gates packet check failure.
// [R16] Protected write flags other comm fault.
// [R17] Alert holds while unmasked status stands.
// [R18] Clean sample resets violation run.
// [R19] Host writes mask as one block.
module ffam_fault_alert
  import ffam_pkg::*;
#(
  parameter int SYNC_LOSS_CYCLES = SYNC_LOSS_CYC
)
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_cmd_start,
  input wire logic [7:0] i_cmd_code,
  input wire logic i_wr_valid,
  input wire logic [7:0] i_wr_byte,
  input wire logic i_xfer_stop,
  input wire logic i_rd_req,
  input wire logic [2:0] i_rd_idx,
  output logic [7:0] o_rd_byte,
  output logic o_rd_valid,
  input wire logic i_pec_fail,
  input wire logic i_write_protect,
  input wire logic i_vout_valid,
  input wire logic i_vout_ov_viol,
  input wire logic i_vout_uv_viol,
  output logic o_vout_ov_fault,
  output logic o_vout_uv_fault,
  output logic o_lowside_on,
  input wire logic i_temp_valid,
  input wire logic [15:0] i_temp_raw,
  output logic o_temp_valid,
  output logic [15:0] o_ext_temp,
  input wire logic i_aux_valid,
  input wire logic [15:0] i_aux_sample,
  input wire logic [15:0] i_aux_uv_limit,
  input wire logic [15:0] i_aux_ov_limit,
  input wire logic i_sync_enable,
  input wire logic i_sync_pin,
  input wire logic [MASK_W-1:0] i_status,
  input wire logic i_clear_faults,
  output logic [MASK_W-1:0] o_local_status,
  output logic o_host_alert_out
);
  // ==========================================================================
  // Registers and working state.
  logic [7:0] cfg_q; // Output fault filter configuration.
  logic [15:0] gain_q; // External temperature divisor.
  logic [15:0] bias_q; // External temperature offset.
  logic [MASK_W-1:0] mask_q; // Alert mask, byte k masks status byte k.
  logic [MASK_W-1:0] shadow_q; // Incoming write bytes before commit.
  logic [7:0] cmd_q; // Command of the current transaction.
  logic [2:0] idx_q; // Data bytes received so far.
  ffam_wr_e wr_q; // Write sequencer state.
  logic [MASK_W-1:0] local_q; // Flags raised by this block.
  logic ov_latched_q; // Overvoltage fault held until cleared.
  logic sync_meta_q; // First synchroniser stage, read only by sync_q.
  logic sync_q; // Second synchroniser stage.
  logic sync_prev_q; // Previous synchronised level for edge detection.
  logic [31:0] sync_cnt_q; // Cycles since the last sync edge.
  logic viol_trip; // Filter reached its run length.
  logic cmd_known; // Command code belongs to this block.
  logic [2:0] cmd_len; // Data bytes the command expects.
  logic [MASK_W-1:0] set_vec; // Flags raised this cycle.
  logic commit; // Transfer ended with a complete, permitted write.
  logic aux_uv_warn; // Aux sample under the warning level.
  logic aux_ov_warn; // Aux sample over the warning level.
  logic sync_lost; // Timeout reached without a sync edge.

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // ==========================================================================
  // Command decode.
  always_comb
  begin
    cmd_known = 1'b1;
    cmd_len = LEN_WORD;
    unique case (i_cmd_code)
      CMD_FILTER_CFG: cmd_len = LEN_BYTE;
      CMD_TEMP_GAIN, CMD_TEMP_BIAS: cmd_len = LEN_WORD;
      CMD_ALERT_MASK: cmd_len = LEN_MASK;
      default: cmd_known = 1'b0;
    endcase
  end

  // A write counts only if the stop ends a full data phase.
  assign commit = i_xfer_stop && (wr_q == WR_DATA) && !i_write_protect &&
                  (idx_q == ((cmd_q == CMD_FILTER_CFG) ? LEN_BYTE :
                             (cmd_q == CMD_ALERT_MASK) ? LEN_MASK : LEN_WORD));

  // ==========================================================================
  // Write sequencer; the block write opens with its byte count, byte 0 next.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      wr_q <= WR_IDLE;
      cmd_q <= 8'h00;
      idx_q <= 3'h0;
      shadow_q <= '0;
    end
    else if (i_cmd_start)
    begin
      cmd_q <= i_cmd_code;
      idx_q <= 3'h0;
      wr_q <= !cmd_known ? WR_BAD : (cmd_len == LEN_MASK) ? WR_COUNT : WR_DATA; // R19
    end
    else if (i_xfer_stop)
    begin
      wr_q <= WR_IDLE;
    end
    else if (i_wr_valid)
    begin
      unique case (wr_q)
        WR_COUNT: wr_q <= (i_wr_byte == {5'h0, LEN_MASK}) ? WR_DATA : WR_BAD; // R19
        WR_DATA:
        begin
          // Bytes fill from the low end; overflow is treated as bad data.
          if (idx_q == LEN_MASK)
          begin
            wr_q <= WR_BAD;
          end
          else
          begin
            shadow_q[idx_q*8 +: 8] <= i_wr_byte; // R4
            idx_q <= idx_q + 3'h1;
          end
        end
        WR_IDLE, WR_BAD: wr_q <= wr_q;
      endcase
    end
  end

  // ==========================================================================
  // Register commit at the stop of a complete write.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      cfg_q <= CFG_RESET;
      gain_q <= GAIN_RESET;
      bias_q <= BIAS_RESET;
      mask_q <= MASK_RESET;
    end
    else if (commit)
    begin
      unique case (cmd_q)
        CMD_FILTER_CFG: cfg_q <= shadow_q[7:0];
        CMD_TEMP_GAIN: gain_q <= shadow_q[15:0];
        CMD_TEMP_BIAS: bias_q <= shadow_q[15:0];
        CMD_ALERT_MASK: mask_q <= shadow_q; // R4
        default: cfg_q <= cfg_q;
      endcase
    end
  end

  // ==========================================================================
  // Read port: words low byte first; block read returns its count at index 0.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      o_rd_byte <= 8'h00;
      o_rd_valid <= 1'b0;
    end
    else
    begin
      o_rd_valid <= i_rd_req;
      if (i_rd_req)
      begin
        unique case (cmd_q)
          CMD_FILTER_CFG: o_rd_byte <= (i_rd_idx == 3'h0) ? cfg_q : 8'h00;
          CMD_TEMP_GAIN: o_rd_byte <= i_rd_idx[0] ? gain_q[15:8] : gain_q[7:0];
          CMD_TEMP_BIAS: o_rd_byte <= i_rd_idx[0] ? bias_q[15:8] : bias_q[7:0];
          CMD_ALERT_MASK:
          begin
            // Index 0 carries the count, then mask bytes 0 to 6.
            if (i_rd_idx == 3'h0)
            begin
              o_rd_byte <= {5'h0, LEN_MASK};
            end
            else
            begin
              o_rd_byte <= mask_q[(i_rd_idx - 3'h1)*8 +: 8];
            end
          end
          default: o_rd_byte <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================================
  // Output voltage violation filter and crowbar.
  ffam_viol_filter #(.CNT_W(CFG_VIOL_W)) u_filter
  (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_sample_valid(i_vout_valid),
    .i_violate(i_vout_ov_viol || i_vout_uv_viol),
    .i_limit(cfg_q[CFG_VIOL_LSB +: CFG_VIOL_W]),
    .o_trip(viol_trip)
  );

  // The tripping sample decides which fault starts; overvoltage takes priority.
  assign o_vout_ov_fault = viol_trip && i_vout_ov_viol; // R1
  assign o_vout_uv_fault = viol_trip && !i_vout_ov_viol; // R1

  // Overvoltage is held so the low-side device stays on until faults are cleared.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      ov_latched_q <= 1'b0;
      o_lowside_on <= 1'b0;
    end
    else
    begin
      ov_latched_q <= o_vout_ov_fault || (ov_latched_q && !i_clear_faults);
      o_lowside_on <= ov_latched_q && cfg_q[CFG_CROWBAR_BIT]; // R2
    end
  end

  // ==========================================================================
  // External temperature scaling; a zero gain yields the bias alone.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      o_ext_temp <= 16'h0000;
      o_temp_valid <= 1'b0;
    end
    else
    begin
      o_temp_valid <= i_temp_valid;
      if (i_temp_valid)
      begin
        o_ext_temp <= ((gain_q == 16'h0000) ? 16'h0000 : i_temp_raw / gain_q) + bias_q; // R3
      end
    end
  end

  // ==========================================================================
  // Aux monitor warnings, compared in percent to avoid a divider.
  assign aux_uv_warn = ({16'h0, i_aux_sample} * PCT_DEN) <
                       ({16'h0, i_aux_uv_limit} * UV_WARN_PCT); // R8
  assign aux_ov_warn = ({16'h0, i_aux_sample} * PCT_DEN) >
                       ({16'h0, i_aux_ov_limit} * OV_WARN_PCT); // R9

  // ==========================================================================
  // Sync clock watchdog; the pin is synchronised before any edge logic.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      sync_meta_q <= 1'b0;
      sync_q <= 1'b0;
      sync_prev_q <= 1'b0;
    end
    else
    begin
      sync_meta_q <= i_sync_pin;
      sync_q <= sync_meta_q;
      sync_prev_q <= sync_q;
    end
  end

  // The count saturates so a lost clock raises one event, not a stream.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn || !i_sync_enable || (sync_q != sync_prev_q))
    begin
      sync_cnt_q <= 32'h0;
    end
    else if (sync_cnt_q < SYNC_LOSS_CYCLES)
    begin
      sync_cnt_q <= sync_cnt_q + 32'h1;
    end
  end
  assign sync_lost = (sync_cnt_q == SYNC_LOSS_CYCLES - 1) && i_sync_enable &&
                     (sync_q == sync_prev_q); // R10

  // ==========================================================================
  // Local sticky flags: a set in the clearing cycle survives.
  always_comb
  begin
    set_vec = '0;
    set_vec[BIT_AUX_UV_WARN] = i_aux_valid && aux_uv_warn; // R8
    set_vec[BIT_AUX_OV_WARN] = i_aux_valid && aux_ov_warn; // R9
    set_vec[BIT_SW_PERIOD] = sync_lost; // R10
    set_vec[BIT_BAD_CMD] = i_cmd_start && !cmd_known; // R13
    set_vec[BIT_BAD_DATA] = (i_wr_valid && !i_xfer_stop && !i_cmd_start &&
                             ((wr_q == WR_COUNT && i_wr_byte != {5'h0, LEN_MASK}) ||
                              (wr_q == WR_DATA && idx_q == LEN_MASK))) ||
                            (i_xfer_stop && wr_q == WR_DATA && idx_q != 3'h0 &&
                             !i_write_protect && !commit); // R14
    set_vec[BIT_PEC_FAIL] = i_pec_fail; // R15
    set_vec[BIT_COMM_OTHER] = i_xfer_stop && (wr_q == WR_DATA) && (idx_q != 3'h0) &&
                              i_write_protect; // R16
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      local_q <= '0;
    end
    else
    begin
      local_q <= set_vec | (i_clear_faults ? '0 : local_q);
    end
  end
  assign o_local_status = local_q;

  // ==========================================================================
  // Alert: any unmasked status bit holds it; registered for a clean pin.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      o_host_alert_out <= 1'b0;
    end
    else
    begin
      o_host_alert_out <= |((i_status | local_q) & ~mask_q); // R5 R6 R7 R11 R12 R17
    end
  end

  // ==========================================================================
  // Checks.
  sequence s_mask_commit;
    commit && (cmd_q == CMD_ALERT_MASK);
  endsequence
  a_mask_load: assert property (s_mask_commit |=> (mask_q == $past(shadow_q))) // R4
    else $error("mask block not loaded");
  a_alert_level: assert property ($past(|((i_status | local_q) & ~mask_q)) == o_host_alert_out) // R17
    else $error("alert does not follow unmasked status");
  a_mask_blocks: assert property ((&mask_q && $stable(mask_q)) |=> !o_host_alert_out) // R5
    else $error("fully masked status raised alert");
  a_phase_gate: assert property ((i_status == (56'h1 << BIT_PHASE_INIT) && local_q == '0 &&
    !mask_q[BIT_PHASE_INIT]) |=> o_host_alert_out) // R6
    else $error("unmasked phase init error did not alert");
  a_crowbar_on: assert property ((o_vout_ov_fault && cfg_q[CFG_CROWBAR_BIT] && !i_clear_faults
    && !commit) |=> ##1 o_lowside_on) // R2
    else $error("crowbar did not engage");
  a_crowbar_off: assert property (!cfg_q[CFG_CROWBAR_BIT] && $stable(cfg_q) |=> !o_lowside_on) // R2
    else $error("low-side on without crowbar");
  a_temp_calc: assert property ((i_temp_valid && gain_q != 16'h0000) |=>
    (o_ext_temp == $past(i_temp_raw) / $past(gain_q) + $past(bias_q)) && o_temp_valid) // R3
    else $error("temperature scaling wrong");
  a_uv_warn: assert property ((i_aux_valid && aux_uv_warn) |=> local_q[BIT_AUX_UV_WARN]) // R8
    else $error("aux uv warning lost");
  a_ov_warn: assert property ((i_aux_valid && aux_ov_warn) |=> local_q[BIT_AUX_OV_WARN]) // R9
    else $error("aux ov warning lost");
  a_sync_loss: assert property (sync_lost |=> local_q[BIT_SW_PERIOD]) // R10
    else $error("sync loss not flagged");
  a_bad_cmd: assert property ((i_cmd_start && !cmd_known) |=> local_q[BIT_BAD_CMD]) // R13
    else $error("invalid command not flagged");
  a_pec_flag: assert property (i_pec_fail |=> local_q[BIT_PEC_FAIL]) // R15
    else $error("packet check failure not flagged");
  a_protect_write: assert property (set_vec[BIT_COMM_OTHER] |=> local_q[BIT_COMM_OTHER] &&
    $stable(cfg_q) && $stable(mask_q)) // R16
    else $error("protected write not refused");
endmodule // ffam_fault_alert
`default_nettype wire

// *** rtl/ffam_pkg.sv ***
// Purpose: Shared constants for the fault filter and alert mask block.
// Assumes: 50 MHz system clock; command codes arrive already decoded from the bus.
// Notes: Every offset, field position, reset value and timing count lives here.
package ffam_pkg;
  // ==========================================================================
  // Command codes of the four registers.
  localparam logic [7:0] CMD_FILTER_CFG = 8'hd8;
  localparam logic [7:0] CMD_TEMP_GAIN = 8'hd9;
  localparam logic [7:0] CMD_TEMP_BIAS = 8'hda;
  localparam logic [7:0] CMD_ALERT_MASK = 8'hdb;
  // ==========================================================================
  // Field layout of output_fault_filter_cfg.
  localparam int CFG_VIOL_LSB = 0;
  localparam int CFG_VIOL_W = 4;
  localparam int CFG_CROWBAR_BIT = 7;
  // ==========================================================================
  // Transfer lengths in data bytes.
  localparam logic [2:0] LEN_BYTE = 3'h1;
  localparam logic [2:0] LEN_WORD = 3'h2;
  localparam logic [2:0] LEN_MASK = 3'h7;
  localparam int MASK_W = 56;
  // ==========================================================================
  // Reset values; a gain of one keeps the divider meaningful from reset.
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [15:0] GAIN_RESET = 16'h0001;
  localparam logic [15:0] BIAS_RESET = 16'h0000;
  localparam logic [55:0] MASK_RESET = 56'h0;
  // ==========================================================================
  // Bit positions inside the 56-bit status and mask vectors.
  localparam int BIT_PHASE_INIT = 55;
  localparam int BIT_GROUP_COMM = 54;
  localparam int BIT_AUX_UV_WARN = 53;
  localparam int BIT_AUX_OV_WARN = 52;
  localparam int BIT_SW_PERIOD = 51;
  localparam int BIT_GROUP_RAIL = 50;
  localparam int BIT_AUX_UV_FAULT = 49;
  localparam int BIT_AUX_OV_FAULT = 48;
  localparam int BIT_BAD_CMD = 39;
  localparam int BIT_BAD_DATA = 38;
  localparam int BIT_PEC_FAIL = 37;
  localparam int BIT_COMM_OTHER = 33;
  // ==========================================================================
  // Warning thresholds as percentages of the fault limits.
  localparam logic [31:0] UV_WARN_PCT = 32'd110;
  localparam logic [31:0] OV_WARN_PCT = 32'd95;
  localparam logic [31:0] PCT_DEN = 32'd100;
  // ==========================================================================
  // Sync loss timeout: least time without a sync edge, rounded up to cycles.
  localparam int CLK_PERIOD_NS = 20;
  localparam int SYNC_LOSS_NS = 20000;
  localparam int SYNC_LOSS_CYC = (SYNC_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================================
  // Write sequencer states.
  typedef enum logic [1:0] {WR_IDLE, WR_COUNT, WR_DATA, WR_BAD} ffam_wr_e;
endpackage

// *** rtl/ffam_viol_filter.sv ***
// Purpose: Counts consecutive output voltage limit violations.
// Assumes: Samples and violation flags come from logic on the same clock.
// Notes: Trips on the violation whose number equals limit plus one.
`timescale 1ns/1ns
`default_nettype none
module ffam_viol_filter
#(
  parameter int CNT_W = 4
)
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_sample_valid,
  input wire logic i_violate,
  input wire logic [CNT_W-1:0] i_limit,
  output logic o_trip
);
  // Run length seen so far; one wider than the limit so it never wraps.
  logic [CNT_W:0] run_q;
  // The current violation completes the run when run_q already equals the limit.
  logic run_full;

  assign run_full = (run_q == {1'b0, i_limit});
  // Trip is a one-cycle pulse when the limit is above zero, qualified by the sample itself.
  assign o_trip = i_sample_valid && i_violate && run_full; // R1

  // ==========================================================================
  // Run counter: a clean sample breaks the run, a trip restarts it.
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      run_q <= '0;
    end
    else if (i_sample_valid)
    begin
      if (!i_violate)
      begin
        run_q <= '0; // R18
      end
      else if (run_full)
      begin
        run_q <= '0;
      end
      else
      begin
        run_q <= run_q + 1'b1;
      end
    end
  end

  a_trip_run_len: assert property (@(posedge i_clk) disable iff (!i_rstn) // R1
    o_trip |-> (run_q == {1'b0, i_limit}))
    else $error("filter tripped at wrong run length");
  a_clean_resets: assert property (@(posedge i_clk) disable iff (!i_rstn) // R18
    (i_sample_valid && !i_violate) |=> (run_q == '0))
    else $error("clean sample did not reset run");
endmodule // ffam_viol_filter
`default_nettype wire

// *** testbench/ffam_host_model.sv ***
// Purpose: Host controller model that drives the decoded command port.
// Assumes: Transfers arrive as start, data and stop strobes on i_clk.
// Notes: Released data lines carry the inverse of their last value.
`timescale 1ns/1ns
`default_nettype none
module ffam_host_model
(
  input wire logic i_clk,
  output logic o_cmd_start,
  output logic [7:0] o_cmd_code,
  output logic o_wr_valid,
  output logic [7:0] o_wr_byte,
  output logic o_xfer_stop,
  output logic o_rd_req,
  output logic [2:0] o_rd_idx,
  input wire logic [7:0] i_rd_byte,
  input wire logic i_rd_valid
);
  // ==========================================================================
  // Idle bus.
  // All strobes start low so nothing is taken during reset.
  initial
  begin
    {o_cmd_start, o_wr_valid, o_xfer_stop, o_rd_req} = 4'h0;
    {o_cmd_code, o_wr_byte, o_rd_idx} = 19'h0;
  end
  // Start, then n data bytes low byte first, then stop as the commit.
  task automatic wr(input logic [7:0] c, input int n, input logic [63:0] d);
    @(posedge i_clk);
    o_cmd_start <= 1'b1;
    o_cmd_code <= c;
    for (int k = 0; k < n; k++)
    begin
      @(posedge i_clk);
      o_cmd_start <= 1'b0;
      o_wr_valid <= 1'b1;
      o_wr_byte <= d[8*k+:8];
    end
    @(posedge i_clk);
    o_cmd_start <= 1'b0;
    o_wr_valid <= 1'b0;
    o_wr_byte <= ~o_wr_byte;
    o_xfer_stop <= 1'b1;
    @(posedge i_clk);
    o_xfer_stop <= 1'b0;
    o_cmd_code <= ~o_cmd_code;
  endtask
  // Start, one byte request, then a stop with no data to close it.
  task automatic rd(input logic [7:0] c, input logic [2:0] i, output logic [7:0] v,
    output logic ok);
    @(posedge i_clk);
    o_cmd_start <= 1'b1;
    o_cmd_code <= c;
    @(posedge i_clk);
    o_cmd_start <= 1'b0;
    o_rd_req <= 1'b1;
    o_rd_idx <= i;
    @(posedge i_clk);
    o_rd_req <= 1'b0;
    o_rd_idx <= ~i;
    o_xfer_stop <= 1'b1;
    #1;
    v = i_rd_byte;
    ok = i_rd_valid;
    @(posedge i_clk);
    o_xfer_stop <= 1'b0;
  endtask
endmodule // ffam_host_model
`default_nettype wire

// *** testbench/fault_filter_and_alert_mask_tb.sv ***
// Purpose: Self-checking bench for the fault filter and alert mask block.
// Assumes: Sync loss timeout shortened to 16 cycles.
// Notes: Expectations come from the package constants and from hand-worked literal values.
`timescale 1ns/1ns
`default_nettype none
module fault_filter_and_alert_mask_tb import ffam_pkg::*;;
  // ==========================================================================
  // Stimulus and observation signals.
  logic i_clk = 1'b0, i_rstn = 1'b0, i_pec_fail = '0, i_write_protect = '0;
  logic i_vout_valid = '0, i_vout_ov_viol = '0, i_vout_uv_viol = '0, i_temp_valid = '0;
  logic i_aux_valid = '0, i_sync_enable = '0, i_sync_pin = '0, i_clear_faults = '0;
  logic [15:0] i_temp_raw = '0, i_aux_sample = '0, i_aux_uv_limit = '0, i_aux_ov_limit = '0;
  logic [MASK_W-1:0] i_status = '0, o_local_status;
  logic i_cmd_start, i_wr_valid, i_xfer_stop, i_rd_req, o_rd_valid, o_vout_ov_fault;
  logic o_vout_uv_fault, o_lowside_on, o_temp_valid, o_host_alert_out, rok;
  logic [7:0] i_cmd_code, i_wr_byte, o_rd_byte, rv;
  logic [2:0] i_rd_idx;
  logic [15:0] o_ext_temp;
  int num_errors = 0, n_checks = 0;
  int bl[5] = '{BIT_PHASE_INIT, BIT_GROUP_COMM, BIT_GROUP_RAIL, BIT_AUX_UV_FAULT,
    BIT_AUX_OV_FAULT};
  localparam logic [55:0] MPAT = 56'h77665544332211;
  always #10 i_clk = ~i_clk;
  ffam_fault_alert #(.SYNC_LOSS_CYCLES(16)) dut_u (.i_clk, .i_rstn, .i_cmd_start,
    .i_cmd_code, .i_wr_valid, .i_wr_byte, .i_xfer_stop, .i_rd_req, .i_rd_idx, .o_rd_byte,
    .o_rd_valid, .i_pec_fail, .i_write_protect, .i_vout_valid, .i_vout_ov_viol,
    .i_vout_uv_viol, .o_vout_ov_fault, .o_vout_uv_fault, .o_lowside_on, .i_temp_valid,
    .i_temp_raw, .o_temp_valid, .o_ext_temp, .i_aux_valid, .i_aux_sample, .i_aux_uv_limit,
    .i_aux_ov_limit, .i_sync_enable, .i_sync_pin, .i_status, .i_clear_faults,
    .o_local_status, .o_host_alert_out);
  ffam_host_model host_u (.i_clk, .o_cmd_start(i_cmd_start), .o_cmd_code(i_cmd_code),
    .o_wr_valid(i_wr_valid), .o_wr_byte(i_wr_byte), .o_xfer_stop(i_xfer_stop),
    .o_rd_req(i_rd_req), .o_rd_idx(i_rd_idx), .i_rd_byte(o_rd_byte), .i_rd_valid(o_rd_valid));
  // ==========================================================================
  // Shared helpers.
  task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    n_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Mask write leaves three cycles for the commit and the registered alert.
  task automatic wm(input logic [55:0] m);
    host_u.wr(CMD_ALERT_MASK, 8, {m, 8'h07});
    cyc(3);
  endtask
  // The fault pulse is combinational, so it is looked at in the sample cycle.
  task automatic vs(input logic ov, input logic uv, input logic eo, input logic eu);
    @(posedge i_clk);
    i_vout_valid <= 1'b1;
    i_vout_ov_viol <= ov;
    i_vout_uv_viol <= uv;
    #1;
    chk("ov_fault", o_vout_ov_fault, eo);
    chk("uv_fault", o_vout_uv_fault, eu);
    @(posedge i_clk);
    i_vout_valid <= 1'b0;
  endtask
  task automatic clr();
    @(posedge i_clk);
    i_clear_faults <= 1'b1;
    @(posedge i_clk);
    i_clear_faults <= 1'b0;
    cyc(3);
  endtask
  task automatic aux(input logic [15:0] s, input logic [15:0] u, input logic [15:0] o);
    @(posedge i_clk);
    {i_aux_valid, i_aux_sample, i_aux_uv_limit, i_aux_ov_limit} <= {1'b1, s, u, o};
    @(posedge i_clk);
    i_aux_valid <= 1'b0;
    cyc(2);
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========================================================================
  // Watchdog: far beyond the few hundred cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge i_clk);
    num_errors++;
    wrap_up();
  end
  // ==========================================================================
  // Test sequence.
  initial
  begin
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    cyc(2);
    host_u.rd(CMD_TEMP_GAIN, 3'h0, rv, rok);
    chk("gain_reset", {rok, rv}, 9'h101);
    // Limit two with crowbar; a clean sample breaks the run.
    host_u.wr(CMD_FILTER_CFG, 1, 64'h82);
    vs(1'b1, 1'b0, 1'b0, 1'b0);
    vs(1'b0, 1'b1, 1'b0, 1'b0);
    vs(1'b0, 1'b0, 1'b0, 1'b0);
    vs(1'b1, 1'b0, 1'b0, 1'b0);
    vs(1'b0, 1'b1, 1'b0, 1'b0);
    chk("lowside_pre", o_lowside_on, 1'b0);
    vs(1'b1, 1'b0, 1'b1, 1'b0);
    cyc(3);
    chk("lowside_on", o_lowside_on, 1'b1);
    for (int k = 0; k < 3; k++)
      vs(1'b0, 1'b1, 1'b0, k == 2);
    clr();
    chk("lowside_clr", o_lowside_on, 1'b0);
    host_u.wr(CMD_FILTER_CFG, 1, 64'h00);
    vs(1'b1, 1'b0, 1'b1, 1'b0);
    cyc(3);
    chk("no_crowbar", o_lowside_on, 1'b0);
    // Temperature: 100 / 4 + 10.
    host_u.wr(CMD_TEMP_GAIN, 2, 64'h0004);
    host_u.wr(CMD_TEMP_BIAS, 2, 64'h000a);
    @(posedge i_clk);
    {i_temp_valid, i_temp_raw} <= {1'b1, 16'h0064};
    @(posedge i_clk);
    i_temp_valid <= 1'b0;
    #1;
    chk("temp", {o_temp_valid, o_ext_temp}, {1'b1, 16'h0023});
    // Mask block readback: count byte first, then bytes 0 to 6.
    wm(MPAT);
    for (int k = 0; k < 8; k++)
    begin
      host_u.rd(CMD_ALERT_MASK, 3'(k), rv, rok);
      chk("mask_rd", rv, (k == 0) ? 8'h07 : 8'(MPAT >> (8 * k - 8)));
    end
    host_u.wr(CMD_ALERT_MASK, 8, {~MPAT, 8'h06});
    cyc(3);
    host_u.rd(CMD_ALERT_MASK, 3'h1, rv, rok);
    chk("bad_count", {o_local_status, rv}, {56'h00004000000000, 8'h11});
    clr();
    // Each external source raises, is blocked by its own bit only.
    foreach (bl[j])
    begin
      wm('0);
      @(posedge i_clk);
      i_status <= 56'h1 << bl[j];
      cyc(3);
      chk("alert_on", o_host_alert_out, 1'b1);
      wm(56'h1 << bl[j]);
      chk("alert_blk", o_host_alert_out, 1'b0);
      wm(~(56'h1 << bl[j]));
      chk("alert_sel", o_host_alert_out, 1'b1);
    end
    @(posedge i_clk);
    i_status <= '0;
    wm('0);
    chk("alert_off", o_host_alert_out, 1'b0);
    // Communication faults: unknown code, packet check, protected write.
    host_u.wr(8'hd0, 0, 64'h0);
    @(posedge i_clk);
    i_pec_fail <= 1'b1;
    @(posedge i_clk);
    {i_pec_fail, i_write_protect} <= 2'b01;
    host_u.wr(CMD_FILTER_CFG, 1, 64'h05);
    @(posedge i_clk);
    i_write_protect <= 1'b0;
    host_u.rd(CMD_FILTER_CFG, 3'h0, rv, rok);
    chk("comm_flags", {o_local_status, rv}, {56'h0000a200000000, 8'h00});
    chk("comm_alert", o_host_alert_out, 1'b1);
    wm(56'h0000a200000000);
    chk("comm_mask", o_host_alert_out, 1'b0);
    // A fully set mask must silence the flags that are still standing.
    wm('1);
    chk("mask_all", o_host_alert_out, 1'b0);
    clr();
    // Aux warnings just at and past the percentage thresholds.
    aux(16'd110, 16'd100, 16'd200);
    aux(16'd95, 16'd0, 16'd100);
    chk("aux_edge", o_local_status[53:52], 2'b00);
    aux(16'd109, 16'd100, 16'd200);
    chk("aux_uv", o_local_status[53:52], 2'b10);
    clr();
    aux(16'd96, 16'd0, 16'd100);
    chk("aux_ov", o_local_status[53:52], 2'b01);
    clr();
    // Sync enabled with a still pin trips after the shortened timeout.
    @(posedge i_clk);
    i_sync_enable <= 1'b1;
    // A running sync clock, one edge every eight cycles, must keep the flag low.
    repeat (4)
    begin
      repeat (8) @(posedge i_clk);
      i_sync_pin <= ~i_sync_pin;
    end
    cyc(10);
    chk("sync_early", o_local_status[BIT_SW_PERIOD], 1'b0);
    cyc(20);
    chk("sync_loss", o_local_status[BIT_SW_PERIOD], 1'b1);
    wrap_up();
  end
endmodule // fault_filter_and_alert_mask_tb
`default_nettype wire
